// ==== core/ssir_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssir_top
   import ssir_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              scl_in,
   output logic                   scl_out,
   output logic                   scl_oe,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   output logic                   spi_sample_late,
   output logic                   spi_launch_trailing,
   output logic                   irq
);
   // -----------------------------
   // Declarations
   // -----------------------------
   ssir_bus_if          ev ();
   ssir_state_e         state;
   logic                serial_port_enable;
   logic                stretch_enable;
   logic                start_irq_en;
   logic [6:0]          own_addr;
   logic [7:0]          receive_buffer;
   logic [7:0]          shift;
   logic [3:0]          bit_cnt;
   logic                buffer_full;
   logic                stat_data;
   logic                stat_stop;
   logic                stat_start;
   logic                stat_rw;
   logic [IRQ_W-1:0]    irq_status;
   logic [IRQ_W-1:0]    irq_mask;
   logic [IRQ_W-1:0]    next_irq_status;
   logic [IRQ_W-1:0]    irq_set;
   logic                aw_full;
   logic                w_full;
   logic [ADDR_W-1:0]   aw_addr;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic                next_aw_full;
   logic                next_w_full;
   logic                next_rvalid;
   logic                wr_fire;
   logic                rd_fire;
   logic                rd_rxbuf;
   logic                wr_lo;
   logic                byte_done;
   logic                addr_match;
   logic                load;
   logic                ack_end;
   logic                release_wr;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == ADDR_W'(off));
   endfunction : hit

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, ADDR_STATUS) | hit(a, ADDR_CONTROL) | hit(a, ADDR_OWN) |
               hit(a, ADDR_RXBUF) | hit(a, ADDR_IRQ_STATUS) | hit(a, ADDR_IRQ_MASK);
   endfunction : mapped

   ssir_bus_monitor u_mon (
      .aclk    (aclk),
      .aresetn (aresetn),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .ev      (ev.mon)
   );

   // -----------------------------
   // AXI4-Lite write channel
   // -----------------------------
   assign wr_fire      = aw_full & w_full & ~s_axi_bvalid;
   assign next_aw_full = (aw_full | (s_axi_awvalid & s_axi_awready)) & ~wr_fire;
   assign next_w_full  = (w_full | (s_axi_wvalid & s_axi_wready)) & ~wr_fire;
   assign wr_lo        = wr_fire & w_strb[0];
   assign release_wr   = wr_lo & hit(aw_addr, ADDR_CONTROL) & w_data[CTL_RELEASE];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         aw_full       <= next_aw_full;
         w_full        <= next_w_full;
         s_axi_awready <= ~next_aw_full;
         s_axi_wready  <= ~next_w_full;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // -----------------------------
   // AXI4-Lite read channel
   // -----------------------------
   assign rd_fire     = s_axi_arvalid & s_axi_arready;
   assign rd_rxbuf    = rd_fire & hit(s_axi_araddr, ADDR_RXBUF);
   assign next_rvalid = (s_axi_rvalid & ~s_axi_rready) | rd_fire;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~next_rvalid;
         s_axi_rvalid  <= next_rvalid;
         if (rd_fire) begin
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata <= 32'h0000_0000;
            if (hit(s_axi_araddr, ADDR_STATUS)) begin
               s_axi_rdata[7:0] <= {spi_sample_late, spi_launch_trailing, stat_data, stat_stop,
                                    stat_start, stat_rw, 1'b0, buffer_full};
            end
            if (hit(s_axi_araddr, ADDR_CONTROL)) begin
               s_axi_rdata[3:0] <= {start_irq_en, ~scl_oe, stretch_enable, serial_port_enable};
            end
            if (hit(s_axi_araddr, ADDR_OWN)) begin
               s_axi_rdata[6:0] <= own_addr;
            end
            if (hit(s_axi_araddr, ADDR_RXBUF)) begin
               s_axi_rdata[7:0] <= receive_buffer;
            end
            if (hit(s_axi_araddr, ADDR_IRQ_STATUS)) begin
               s_axi_rdata[IRQ_W-1:0] <= irq_status;
            end
            if (hit(s_axi_araddr, ADDR_IRQ_MASK)) begin
               s_axi_rdata[IRQ_W-1:0] <= irq_mask;
            end
         end
      end
   end

   // -----------------------------
   // Configuration registers
   // -----------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         spi_sample_late     <= 1'b0;
         spi_launch_trailing <= 1'b0;
         serial_port_enable  <= 1'b0;
         stretch_enable      <= 1'b0;
         start_irq_en        <= 1'b0;
         own_addr            <= OWN_ADDR_RESET;
         irq_mask            <= IRQ_RESET;
      end else if (wr_lo) begin
         if (hit(aw_addr, ADDR_STATUS)) begin
            spi_sample_late     <= w_data[ST_SAMPLE_PHASE];
            spi_launch_trailing <= w_data[ST_CLK_EDGE];
         end
         if (hit(aw_addr, ADDR_CONTROL)) begin
            serial_port_enable <= w_data[CTL_ENABLE];
            stretch_enable     <= w_data[CTL_STRETCH];
            start_irq_en       <= w_data[CTL_START_IE];
         end
         if (hit(aw_addr, ADDR_OWN)) begin
            own_addr <= w_data[6:0];
         end
         if (hit(aw_addr, ADDR_IRQ_MASK)) begin
            irq_mask <= w_data[IRQ_W-1:0];
         end
      end
   end

   // -----------------------------
   // Slave receive engine
   // -----------------------------
   assign byte_done  = ev.scl_fall & (bit_cnt == BITS_PER_BYTE);
   assign addr_match = (shift[7:1] == own_addr) & ~shift[0];
   assign load       = byte_done & ((state == S_DATA) | ((state == S_ADDR) & addr_match));
   assign ack_end    = (state == S_ACK) & ev.scl_fall;

   always_ff @(posedge aclk) begin
      if (!aresetn || !serial_port_enable) begin
         state      <= S_IDLE;
         bit_cnt    <= 4'h0;
         shift      <= 8'h00;
         sda_oe     <= 1'b0;
         stat_stop  <= 1'b0;
         stat_start <= 1'b0;
      end else if (ev.stop_det) begin
         state      <= S_IDLE;
         sda_oe     <= 1'b0;
         stat_stop  <= 1'b1;
         stat_start <= 1'b0;
      end else if (ev.start_det) begin
         state      <= S_ADDR;
         bit_cnt    <= 4'h0;
         sda_oe     <= 1'b0;
         stat_start <= 1'b1;
         stat_stop  <= 1'b0;
      end else begin
         case (state)
            S_ADDR, S_DATA: begin
               if (ev.scl_rise && bit_cnt != BITS_PER_BYTE) begin
                  shift   <= {shift[6:0], ev.sda_level};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (byte_done) begin
                  state  <= load ? S_ACK : S_IGNORE;
                  sda_oe <= load;
               end
            end
            S_ACK: begin
               if (ev.scl_fall) begin
                  state   <= S_DATA;
                  bit_cnt <= 4'h0;
                  sda_oe  <= 1'b0;
               end
            end
            S_IDLE, S_IGNORE: begin
               sda_oe <= 1'b0;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // -----------------------------
   // Received byte and status
   // -----------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_buffer <= 8'h00;
         buffer_full    <= 1'b0;
         stat_data      <= 1'b0;
         stat_rw        <= 1'b0;
      end else if (load) begin
         receive_buffer <= shift;
         buffer_full    <= 1'b1;
         stat_data      <= (state == S_DATA);
         if (state == S_ADDR) begin
            stat_rw <= shift[0];
         end
      end else if (rd_rxbuf) begin
         buffer_full <= 1'b0;
      end
   end

   // -----------------------------
   // Clock stretching
   // -----------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || !serial_port_enable) begin
         scl_oe <= 1'b0;
      end else if (ack_end && stretch_enable) begin
         scl_oe <= 1'b1;
      end else if (release_wr) begin
         scl_oe <= 1'b0;
      end
   end

   // -----------------------------
   // Interrupts
   // -----------------------------
   always_comb begin
      irq_set                 = '0;
      irq_set[IRQ_BYTE]       = ack_end | (ev.start_det & serial_port_enable & start_irq_en);
      irq_set[IRQ_STOP]       = ev.stop_det & serial_port_enable;
      irq_set[IRQ_OVERFLOW]   = load & buffer_full & ~rd_rxbuf;
      next_irq_status         = irq_status;
      if (wr_lo && hit(aw_addr, ADDR_IRQ_STATUS)) begin
         next_irq_status = irq_status & ~w_data[IRQ_W-1:0];
      end
      next_irq_status = next_irq_status | irq_set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= IRQ_RESET;
         irq        <= 1'b0;
         scl_out    <= 1'b0;
         sda_out    <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq        <= |(irq_status & irq_mask);
         scl_out    <= 1'b0;
         sda_out    <= 1'b0;
      end
   end

   // -----------------------------
   // Checks
   // -----------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence byte_acked;
      (state == S_ACK) ##1 (state == S_ACK)[*1] ##0 ack_end;
   endsequence

   a_phase_write: assert property (wr_lo && hit(aw_addr, ADDR_STATUS)
      |=> spi_sample_late == $past(w_data[ST_SAMPLE_PHASE])) else $error("sample phase not stored");
   a_edge_write: assert property (wr_lo && hit(aw_addr, ADDR_STATUS)
      |=> spi_launch_trailing == $past(w_data[ST_CLK_EDGE])) else $error("clock edge not stored");
   a_disable_stop: assert property (!serial_port_enable |=> !stat_stop && !stat_start)
      else $error("stop flag kept while disabled");
   a_load_full: assert property (load |=> buffer_full && receive_buffer == $past(shift))
      else $error("byte not loaded");
   a_start_flag: assert property (ev.start_det && serial_port_enable && !ev.stop_det
      |=> stat_start ##0 (irq_status[IRQ_BYTE] || !$past(start_irq_en))) else $error("start not flagged");
   a_ack_irq: assert property (byte_acked |=> irq_status[IRQ_BYTE] && !sda_oe)
      else $error("no interrupt after acknowledge");
   a_ack_drive: assert property (load && !ev.stop_det && !ev.start_det |=> sda_oe [*1] ##0 state == S_ACK)
      else $error("acknowledge not driven");
   a_read_clear: assert property (rd_rxbuf && !load |=> !buffer_full)
      else $error("buffer full not cleared");
   a_stretch_hold: assert property (scl_oe && !release_wr && serial_port_enable |=> scl_oe)
      else $error("clock released early");
   a_stretch_set: assert property (ack_end && stretch_enable && serial_port_enable |=> scl_oe)
      else $error("clock not stretched");
   a_stop_idle: assert property (ev.stop_det && serial_port_enable |=> state == S_IDLE && stat_stop)
      else $error("stop not handled");
   a_overflow: assert property (load && buffer_full && !rd_rxbuf |=> irq_status[IRQ_OVERFLOW])
      else $error("overflow missed");
   a_no_match: assert property (state == S_IGNORE |-> !sda_oe && !load)
      else $error("mismatch acknowledged");
   a_byte_type: assert property (load |=> stat_data == ($past(state) == S_DATA))
      else $error("byte type wrong");
endmodule : ssir_top
`default_nettype wire

// ==== core/ssir_pkg.sv ====
// Functional notes
// - SPI master: sample_phase set samples at end, clear samples mid data time.
// - Clock edge select set launches on active-to-idle, clear on idle-to-active.
// - Stop flag is cleared whenever serial_port_enable is cleared.
// - buffer_full sets when a received byte lands in receive_buffer.
// - Start detected sets start bit; interrupt only if start interrupt enabled.
// - Matching address with write direction is acknowledged, then interrupt flag set.
// - Reading receive_buffer returns the byte and clears buffer_full.
// - With stretch_enable, SCL held low after a byte until clock_release written.
// - Each data byte after the address is acknowledged, then interrupt flag set.
// - Stop condition sets stop bit and returns the bus to idle.
// - Byte completing while buffer_full still set raises receive_overflow.
package ssir_pkg;
   // -----------------------------
   // Register offsets
   // -----------------------------
   localparam logic [7:0] ADDR_STATUS     = 8'h00;
   localparam logic [7:0] ADDR_CONTROL    = 8'h04;
   localparam logic [7:0] ADDR_OWN        = 8'h08;
   localparam logic [7:0] ADDR_RXBUF      = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;
   // -----------------------------
   // Field positions
   // -----------------------------
   localparam int ST_SAMPLE_PHASE = 7;
   localparam int ST_CLK_EDGE     = 6;
   localparam int ST_DATA_ADDR    = 5;
   localparam int ST_STOP         = 4;
   localparam int ST_START        = 3;
   localparam int ST_READ_WRITE   = 2;
   localparam int ST_UPDATE_ADDR  = 1;
   localparam int ST_BUFFER_FULL  = 0;
   localparam int CTL_ENABLE      = 0;
   localparam int CTL_STRETCH     = 1;
   localparam int CTL_RELEASE     = 2;
   localparam int CTL_START_IE    = 3;
   localparam int IRQ_BYTE        = 0;
   localparam int IRQ_STOP        = 1;
   localparam int IRQ_OVERFLOW    = 2;
   localparam int IRQ_W           = 3;
   // -----------------------------
   // Reset values and codes
   // -----------------------------
   localparam logic [6:0]       OWN_ADDR_RESET = 7'h2A;
   localparam logic [IRQ_W-1:0] IRQ_RESET      = 3'h0;
   localparam logic [3:0]       BITS_PER_BYTE  = 4'h8;
   localparam logic [1:0]       RESP_OKAY      = 2'h0;
   localparam logic [1:0]       RESP_SLVERR    = 2'h2;
   typedef enum {S_IDLE, S_ADDR, S_ACK, S_DATA, S_IGNORE} ssir_state_e;
endpackage : ssir_pkg

// ==== core/ssir_bus_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ssir_bus_if;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic sda_level;
   modport mon  (output scl_rise, scl_fall, start_det, stop_det, sda_level);
   modport core (input scl_rise, scl_fall, start_det, stop_det, sda_level);
endinterface : ssir_bus_if
`default_nettype wire

// ==== core/ssir_bus_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssir_bus_monitor
   import ssir_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic scl_in,
   input  wire logic sda_in,
   ssir_bus_if.mon   ev
);
   // -----------------------------
   // Pin synchronisers
   // -----------------------------
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic       scl_q;
   logic       sda_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
      end else begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
      end
   end

   // -----------------------------
   // Edge and condition detect
   // -----------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_q        <= 1'b1;
         sda_q        <= 1'b1;
         ev.scl_rise  <= 1'b0;
         ev.scl_fall  <= 1'b0;
         ev.start_det <= 1'b0;
         ev.stop_det  <= 1'b0;
         ev.sda_level <= 1'b1;
      end else begin
         scl_q        <= scl_sync[1];
         sda_q        <= sda_sync[1];
         ev.scl_rise  <= scl_sync[1] & ~scl_q;
         ev.scl_fall  <= ~scl_sync[1] & scl_q;
         ev.start_det <= scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
         ev.stop_det  <= scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
         ev.sda_level <= sda_sync[1];
      end
   end
endmodule : ssir_bus_monitor
`default_nettype wire

// ==== testbench/ssir_i2c_master.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssir_i2c_master (
   output var logic scl_drive,
   output var logic sda_drive,
   input  wire logic scl_line,
   input  wire logic sda_line
);
   int stuck = 0;
   initial begin
      scl_drive = 1'h1;
      sda_drive = 1'h1;
   end
   // ---
   // Bus conditions
   // ---
   task automatic scl_high();
      int k;
      scl_drive = 1'h1;
      for (k = 0; k < 2000 && scl_line !== 1'h1; k++) #5;
      if (k == 2000) stuck++;
   endtask : scl_high
   task automatic start_cond();
      #1;
      sda_drive = 1'h1;
      scl_high();
      #40 sda_drive = 1'h0;
      #40 scl_drive = 1'h0;
      #40;
   endtask : start_cond
   task automatic send_byte(input logic [7:0] b, output logic ack);
      #1;
      for (int i = 7; i >= 0; i--) begin
         sda_drive = b[i];
         #40;
         scl_high();
         #80 scl_drive = 1'h0;
         #40;
      end
      sda_drive = 1'h1;
      #40;
      scl_high();
      ack = (sda_line === 1'h0);
      #80 scl_drive = 1'h0;
      #40;
   endtask : send_byte
   task automatic stop_cond();
      #1;
      sda_drive = 1'h0;
      #40;
      scl_high();
      #40 sda_drive = 1'h1;
      #40;
   endtask : stop_cond
endmodule : ssir_i2c_master
`default_nettype wire

// ==== testbench/sync_serial_status_i2c_slave_rx_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module sync_serial_status_i2c_slave_rx_test import ssir_pkg::*;;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic scl_out, scl_oe, sda_out, sda_oe, spi_sample_late, spi_launch_trailing, irq;
   logic scl_drive, sda_drive;
   int failures = 0, checks = 0;
   wire logic scl_line = scl_drive & ~(scl_oe & ~scl_out);
   wire logic sda_line = sda_drive & ~(sda_oe & ~sda_out);
   always #2.5 aclk = ~aclk;
   ssir_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .spi_sample_late(spi_sample_late),
      .spi_launch_trailing(spi_launch_trailing), .irq(irq));
   ssir_i2c_master i_master (.scl_drive(scl_drive), .sda_drive(sda_drive),
      .scl_line(scl_line), .sda_line(sda_line));
   // ---
   // Helpers
   // ---
   task automatic finish_test();
      if (i_master.stuck != 0) failures++;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 64 && s_axi_bvalid !== 1'h1; n++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      if (n == 64) chk("write timeout", 32'h0, 32'h1);
      if (n == 64) finish_test();
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 64 && s_axi_rvalid !== 1'h1; n++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      if (n == 64) chk("read timeout", 32'h0, 32'h1);
      if (n == 64) finish_test();
   endtask : axi_rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(nm, e, d);
      chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask : rd
   task automatic send(input logic [7:0] b, input logic e, input string nm);
      logic ack;
      i_master.send_byte(b, ack);
      chk(nm, {31'h0, e}, {31'h0, ack});
   endtask : send
   // ---
   // Scenarios
   // ---
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rd(ADDR_STATUS, 32'h0, "status reset");
      rd(ADDR_CONTROL, 32'h4, "control reset");
      rd(ADDR_OWN, {25'h0, OWN_ADDR_RESET}, "own reset");
      rd(ADDR_IRQ_MASK, 32'h0, "mask reset");
      rd(ADDR_IRQ_STATUS, 32'h0, "irq status reset");
      axi_rd(8'h18, d, r);
      chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("unmapped rdata", 32'h0, d);
      axi_wr(8'h18, 32'hFF, r);
      chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      s_axi_wstrb <= 4'h0;
      wr(ADDR_OWN, 32'h55);
      s_axi_wstrb <= 4'hF;
      rd(ADDR_OWN, {25'h0, OWN_ADDR_RESET}, "own strobe off");
      wr(ADDR_STATUS, 32'hFF);
      rd(ADDR_STATUS, 32'hC0, "status writable");
      chk("sample late", 32'h1, 32'(spi_sample_late));
      chk("launch trailing", 32'h1, 32'(spi_launch_trailing));
      wr(ADDR_STATUS, 32'h40);
      rd(ADDR_STATUS, 32'h40, "status edge only");
      chk("sample mid", 32'h0, 32'(spi_sample_late));
      wr(ADDR_STATUS, 32'h0);
      rd(ADDR_STATUS, 32'h0, "status cleared");
      chk("launch leading", 32'h0, 32'(spi_launch_trailing));
      $display("register test done");
   endtask : t_regs
   task automatic t_receive();
      logic [31:0] d;
      logic [1:0] r;
      wr(ADDR_CONTROL, 32'hB);
      i_master.start_cond();
      rd(ADDR_STATUS, 32'h8, "start bit");
      rd(ADDR_IRQ_STATUS, 32'h1, "start irq");
      chk("irq masked", 32'h0, 32'(irq));
      wr(ADDR_IRQ_MASK, 32'h7);
      rd(ADDR_IRQ_MASK, 32'h7, "mask");
      chk("irq unmasked", 32'h1, 32'(irq));
      wr(ADDR_IRQ_STATUS, 32'h1);
      rd(ADDR_IRQ_STATUS, 32'h0, "irq cleared");
      chk("irq low", 32'h0, 32'(irq));
      send({OWN_ADDR_RESET, 1'h0}, 1'h1, "address ack");
      rd(ADDR_IRQ_STATUS, 32'h1, "address irq");
      chk("stretch", 32'h1, 32'(scl_oe));
      rd(ADDR_STATUS, 32'h9, "address status");
      wr(ADDR_IRQ_STATUS, 32'h1);
      rd(ADDR_RXBUF, {24'h0, OWN_ADDR_RESET, 1'h0}, "address byte");
      rd(ADDR_STATUS, 32'h8, "full cleared");
      rd(ADDR_CONTROL, 32'hB, "still stretched");
      wr(ADDR_CONTROL, 32'hF);
      rd(ADDR_CONTROL, 32'hF, "released");
      send(8'hA5, 1'h1, "data ack");
      rd(ADDR_IRQ_STATUS, 32'h1, "data irq");
      rd(ADDR_STATUS, 32'h29, "data status");
      wr(ADDR_IRQ_STATUS, 32'h1);
      wr(ADDR_CONTROL, 32'hF);
      send(8'h3C, 1'h1, "second ack");
      rd(ADDR_IRQ_STATUS, 32'h5, "overflow");
      rd(ADDR_RXBUF, 32'h3C, "second byte");
      wr(ADDR_IRQ_STATUS, 32'h5);
      wr(ADDR_CONTROL, 32'hF);
      i_master.stop_cond();
      axi_rd(ADDR_STATUS, d, r);
      chk("stop bit", 32'h1, 32'(d[ST_STOP]));
      rd(ADDR_IRQ_STATUS, 32'h2, "stop irq");
      chk("pins free", 32'h0, {30'h0, scl_oe, sda_oe});
      wr(ADDR_CONTROL, 32'h0);
      axi_rd(ADDR_STATUS, d, r);
      chk("stop on disable", 32'h0, 32'(d[ST_STOP]));
      wr(ADDR_IRQ_STATUS, 32'h7);
      $display("receive test done");
   endtask : t_receive
   task automatic t_refuse();
      logic [31:0] d;
      logic [1:0] r;
      wr(ADDR_CONTROL, 32'h1);
      i_master.start_cond();
      rd(ADDR_IRQ_STATUS, 32'h0, "start no irq");
      send(8'h26, 1'h0, "wrong address");
      rd(ADDR_IRQ_STATUS, 32'h0, "wrong address irq");
      i_master.stop_cond();
      i_master.start_cond();
      send({OWN_ADDR_RESET, 1'h1}, 1'h0, "read direction");
      i_master.stop_cond();
      axi_rd(ADDR_IRQ_STATUS, d, r);
      chk("read direction irq", 32'h0, 32'(d[IRQ_BYTE]));
      wr(ADDR_OWN, 32'h13);
      i_master.start_cond();
      send(8'h26, 1'h1, "new own address");
      chk("no stretch", 32'h0, 32'(scl_oe));
      rd(ADDR_RXBUF, 32'h26, "new address byte");
      i_master.stop_cond();
      $display("refuse test done");
   endtask : t_refuse
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_receive();
      t_refuse();
      finish_test();
   end
endmodule : sync_serial_status_i2c_slave_rx_test
`default_nettype wire
